//--- rtl/fqr_host.sv
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - wait 50ns after reset before chip/output enable
// - wait 150ns after reset before write strobe
// - hold reset 300us after supply valid
// - access allowed right after ready/busy rises
module fqr_host #(
	parameter int POWERUP_CYCLES = fqr_pkg::POWERUP_CYC,
	parameter int ABORT_CYCLES = fqr_pkg::ABORT_CYC
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic ce_in,
	input wire logic [7:0] s_awaddr_in,
	input wire logic s_awvalid_in,
	output logic s_awready_out,
	input wire logic [31:0] s_wdata_in,
	input wire logic [3:0] s_wstrb_in,
	input wire logic s_wvalid_in,
	output logic s_wready_out,
	output logic [1:0] s_bresp_out,
	output logic s_bvalid_out,
	input wire logic s_bready_in,
	input wire logic [7:0] s_araddr_in,
	input wire logic s_arvalid_in,
	output logic s_arready_out,
	output logic [31:0] s_rdata_out,
	output logic [1:0] s_rresp_out,
	output logic s_rvalid_out,
	input wire logic s_rready_in,
	output logic [7:0] fl_addr_out,
	input wire logic [15:0] fl_dq_in,
	output logic [15:0] fl_dq_out,
	output logic fl_dq_oe_out,
	output logic fl_ce_n_out,
	output logic fl_oe_n_out,
	output logic fl_we_n_out,
	output logic fl_rst_n_out,
	input wire logic ready_busy_n_in
);
	fqr_pkg::fqr_state_t st_r, st_nxt;
	logic [23:0] cnt_r, cnt_nxt;
	logic [7:0] gap_r, gap_nxt;
	logic wgap_r, wgap_nxt;
	logic [15:0] dat_r, dat_nxt;
	logic [15:0] wd_r, wd_nxt;
	logic [7:0] qa_r, qa_nxt;
	logic pend_r, pend_nxt, iswr_r, iswr_nxt;
	logic mism_r, mism_nxt, busy_abort_r, busy_abort_nxt;
	logic ce_n_r, oe_n_r, we_n_r, rst_n_r, oe_r;
	logic ce_n_nxt, oe_n_nxt, we_n_nxt, rst_n_nxt, oe_nxt;
	logic [15:0] dq_s;
	logic rb_s;
	logic wr;
	logic [7:0] wr_addr, rd_addr;
	logic [31:0] wr_data, rd_data;
	logic wr_err, rd_err;
	logic [6:0] caps_r, caps_nxt;
	logic sw_rst_r, sw_rst_nxt;

	fqr_sync #(.W(17)) u_sync (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.ce_in(ce_in),
		.d_in({ready_busy_n_in, fl_dq_in}),
		.q_out({rb_s, dq_s})
	);

	fqr_axil u_axil (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.ce_in(ce_in),
		.awaddr_in(s_awaddr_in),
		.awvalid_in(s_awvalid_in),
		.awready_out(s_awready_out),
		.wdata_in(s_wdata_in),
		.wstrb_in(s_wstrb_in),
		.wvalid_in(s_wvalid_in),
		.wready_out(s_wready_out),
		.bresp_out(s_bresp_out),
		.bvalid_out(s_bvalid_out),
		.bready_in(s_bready_in),
		.araddr_in(s_araddr_in),
		.arvalid_in(s_arvalid_in),
		.arready_out(s_arready_out),
		.rdata_out(s_rdata_out),
		.rresp_out(s_rresp_out),
		.rvalid_out(s_rvalid_out),
		.rready_in(s_rready_in),
		.wr_out(wr),
		.wr_addr_out(wr_addr),
		.wr_data_out(wr_data),
		.wr_err_in(wr_err),
		.rd_addr_out(rd_addr),
		.rd_data_in(rd_data),
		.rd_err_in(rd_err)
	);

	// checks a query word against the documented capability value
	function automatic logic query_ok(input logic [7:0] a, input logic [15:0] d);
		unique case (a)
			fqr_pkg::Q_SIMUL_OPS: query_ok = d == fqr_pkg::V_SIMUL_OPS;
			fqr_pkg::Q_BURST: query_ok = d == fqr_pkg::V_BURST;
			fqr_pkg::Q_PAGE: query_ok = d == fqr_pkg::V_PAGE;
			fqr_pkg::Q_ACCEL_MIN: query_ok = d == fqr_pkg::V_ACCEL_MIN;
			fqr_pkg::Q_ACCEL_MAX: query_ok = d == fqr_pkg::V_ACCEL_MAX;
			fqr_pkg::Q_WP_PLACE: query_ok = d == fqr_pkg::V_WP_LOW || d == fqr_pkg::V_WP_HIGH;
			fqr_pkg::Q_PGM_SUSP: query_ok = d == fqr_pkg::V_PGM_SUSP;
			default: query_ok = 1'b1;
		endcase
	endfunction

	function automatic logic [2:0] query_idx(input logic [7:0] a);
		query_idx = 3'(a - fqr_pkg::Q_SIMUL_OPS);
	endfunction

	logic is_query;
	assign is_query = qa_r >= fqr_pkg::Q_SIMUL_OPS && qa_r <= fqr_pkg::Q_PGM_SUSP;

	// register decode
	always_comb begin
		wr_err = !(wr_addr == fqr_pkg::A_CTRL || wr_addr == fqr_pkg::A_CMD);
		rd_err = 1'b0;
		unique case (rd_addr)
			fqr_pkg::A_CTRL: rd_data = {31'h0, sw_rst_r};
			fqr_pkg::A_CMD: rd_data = {iswr_r, 7'h00, qa_r, wd_r};
			fqr_pkg::A_STATUS: rd_data = {24'h0, busy_abort_r, mism_r, rb_s, pend_r, st_r[5:2]};
			fqr_pkg::A_RDATA: rd_data = {16'h0, dat_r};
			fqr_pkg::A_CAPS: rd_data = {25'h0, caps_r};
			default: begin
				rd_data = 32'h0000_0000;
				rd_err = 1'b1;
			end
		endcase
	end

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		gap_nxt = gap_r;
		wgap_nxt = wgap_r;
		dat_nxt = dat_r;
		wd_nxt = wd_r;
		qa_nxt = qa_r;
		pend_nxt = pend_r;
		iswr_nxt = iswr_r;
		mism_nxt = mism_r;
		busy_abort_nxt = busy_abort_r;
		caps_nxt = caps_r;
		sw_rst_nxt = sw_rst_r;
		ce_n_nxt = 1'b1;
		oe_n_nxt = 1'b1;
		we_n_nxt = 1'b1;
		oe_nxt = 1'b0;
		rst_n_nxt = rst_n_r;
		if (wr && wr_addr == fqr_pkg::A_CTRL)
			sw_rst_nxt = wr_data[fqr_pkg::CTRL_RST_BIT];
		// a new command while one is pending is dropped; software polls busy
		if (wr && wr_addr == fqr_pkg::A_CMD && !pend_r) begin
			pend_nxt = 1'b1;
			iswr_nxt = wr_data[fqr_pkg::CMD_WRITE_BIT];
			qa_nxt = wr_data[23:16];
			wd_nxt = wr_data[15:0];
		end
		if (gap_r != 8'h00)
			gap_nxt = gap_r - 8'h01;
		unique case (st_r)
			fqr_pkg::FQR_POWERUP: begin
				rst_n_nxt = 1'b0;
				cnt_nxt = cnt_r + 24'h1;
				if (cnt_r >= 24'(POWERUP_CYCLES - 1)) begin
					st_nxt = fqr_pkg::FQR_IDLE;
					rst_n_nxt = 1'b1;
					gap_nxt = 8'(fqr_pkg::RW_CYC);
					wgap_nxt = 1'b1;
					cnt_nxt = 24'h0;
				end
			end
			fqr_pkg::FQR_RESET: begin
				// reset may land mid program/erase; the device aborts in at most the abort time
				rst_n_nxt = 1'b0;
				cnt_nxt = cnt_r + 24'h1;
				if (cnt_r >= 24'(fqr_pkg::RP_CYC - 1) && !sw_rst_r) begin
					st_nxt = fqr_pkg::FQR_IDLE;
					rst_n_nxt = 1'b1;
					gap_nxt = 8'(fqr_pkg::RW_CYC);
					wgap_nxt = 1'b1;
					cnt_nxt = 24'h0;
				end
			end
			fqr_pkg::FQR_IDLE: begin
				if (sw_rst_r) begin
					st_nxt = fqr_pkg::FQR_RESET;
					rst_n_nxt = 1'b0;
					cnt_nxt = 24'h0;
				end else if (!rb_s) begin
					// busy: count toward the abort bound, then flag it
					cnt_nxt = cnt_r + 24'h1;
					if (cnt_r >= 24'(ABORT_CYCLES))
						busy_abort_nxt = 1'b1;
				end else begin
					cnt_nxt = 24'h0;
					// ready high: access with no extra wait
					if (pend_r && !iswr_r && gap_r <= 8'(fqr_pkg::RW_CYC - fqr_pkg::RH_CYC)) begin
						st_nxt = fqr_pkg::FQR_READ;
						ce_n_nxt = 1'b0;
						oe_n_nxt = 1'b0;
					end else if (pend_r && iswr_r && (gap_r == 8'h00 || !wgap_r)) begin
						st_nxt = fqr_pkg::FQR_WRITE;
						ce_n_nxt = 1'b0;
						we_n_nxt = 1'b0;
						oe_nxt = 1'b1;
						wgap_nxt = 1'b0;
					end
				end
			end
			fqr_pkg::FQR_READ: begin
				ce_n_nxt = 1'b0;
				oe_n_nxt = 1'b0;
				cnt_nxt = cnt_r + 24'h1;
				// two sync stages added on top of access time
				if (cnt_r >= 24'(fqr_pkg::ACC_CYC + 1)) begin
					dat_nxt = dq_s;
					if (is_query) begin
						caps_nxt[query_idx(qa_r)] = query_ok(qa_r, dq_s);
						mism_nxt = mism_r | !query_ok(qa_r, dq_s);
					end
					st_nxt = fqr_pkg::FQR_DONE;
					ce_n_nxt = 1'b1;
					oe_n_nxt = 1'b1;
					cnt_nxt = 24'h0;
				end
			end
			fqr_pkg::FQR_WRITE: begin
				ce_n_nxt = 1'b0;
				oe_nxt = 1'b1;
				cnt_nxt = cnt_r + 24'h1;
				we_n_nxt = cnt_r >= 24'(fqr_pkg::ACC_CYC);
				if (cnt_r >= 24'(fqr_pkg::ACC_CYC + 1)) begin
					st_nxt = fqr_pkg::FQR_DONE;
					ce_n_nxt = 1'b1;
					oe_nxt = 1'b0;
					cnt_nxt = 24'h0;
				end
			end
			fqr_pkg::FQR_DONE: begin
				pend_nxt = 1'b0;
				st_nxt = fqr_pkg::FQR_IDLE;
			end
			default: st_nxt = fqr_pkg::FQR_POWERUP;
		endcase
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st_r <= fqr_pkg::FQR_POWERUP;
			cnt_r <= 24'h0;
			gap_r <= 8'h00;
			wgap_r <= 1'b0;
			dat_r <= 16'h0000;
			wd_r <= 16'h0000;
			qa_r <= 8'h00;
			pend_r <= 1'b0;
			iswr_r <= 1'b0;
			mism_r <= 1'b0;
			busy_abort_r <= 1'b0;
			caps_r <= 7'h00;
			sw_rst_r <= fqr_pkg::CTRL_RESET[0];
			ce_n_r <= 1'b1;
			oe_n_r <= 1'b1;
			we_n_r <= 1'b1;
			oe_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else if (ce_in) begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			gap_r <= gap_nxt;
			wgap_r <= wgap_nxt;
			dat_r <= dat_nxt;
			wd_r <= wd_nxt;
			qa_r <= qa_nxt;
			pend_r <= pend_nxt;
			iswr_r <= iswr_nxt;
			mism_r <= mism_nxt;
			busy_abort_r <= busy_abort_nxt;
			caps_r <= caps_nxt;
			sw_rst_r <= sw_rst_nxt;
			ce_n_r <= ce_n_nxt;
			oe_n_r <= oe_n_nxt;
			we_n_r <= we_n_nxt;
			oe_r <= oe_nxt;
			rst_n_r <= rst_n_nxt;
		end
	end

	assign fl_addr_out = qa_r;
	assign fl_dq_out = wd_r;
	assign fl_dq_oe_out = oe_r;
	assign fl_ce_n_out = ce_n_r;
	assign fl_oe_n_out = oe_n_r;
	assign fl_we_n_out = we_n_r;
	assign fl_rst_n_out = rst_n_r;

	// helper: cycles since reset release
	logic [7:0] since_rel_r;
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in)
			since_rel_r <= 8'h00;
		else if (ce_in && !rst_n_r)
			since_rel_r <= 8'h00;
		else if (ce_in && since_rel_r != 8'hFF)
			since_rel_r <= since_rel_r + 8'h01;
	end

	sequence rst_rise_s;
		!$past(rst_n_r) && rst_n_r;
	endsequence

	reset_access_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		!ce_n_r || !oe_n_r |-> since_rel_r >= 8'(fqr_pkg::RH_CYC) || $past(!ce_n_r))
		else $error("chip enable too soon after reset release");
	reset_write_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		$fell(we_n_r) |-> since_rel_r >= 8'(fqr_pkg::RW_CYC))
		else $error("write strobe too soon after reset release");
	powerup_hold_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		rst_rise_s |-> $past(cnt_r) >= 24'(POWERUP_CYCLES - 1) || $past(st_r) == fqr_pkg::FQR_RESET)
		else $error("reset released before hold time");
	reset_standby_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		!rst_n_r |-> ce_n_r && oe_n_r && we_n_r && !oe_r)
		else $error("bus active while flash in reset");
	busy_block_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		st_r == fqr_pkg::FQR_IDLE && !rb_s && ce_in |=> ce_n_r)
		else $error("access started while flash busy");
	reset_pulse_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		st_r == fqr_pkg::FQR_RESET && $rose(st_r == fqr_pkg::FQR_RESET) && ce_in |=> !rst_n_r)
		else $error("reset pulse too short");
	query_page_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		st_r == fqr_pkg::FQR_READ && st_nxt == fqr_pkg::FQR_DONE && qa_r == fqr_pkg::Q_PAGE && ce_in
		|=> caps_r[2] == (dat_r == fqr_pkg::V_PAGE))
		else $error("page capability check wrong");
	query_mism_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		st_r == fqr_pkg::FQR_READ && st_nxt == fqr_pkg::FQR_DONE && qa_r == fqr_pkg::Q_SIMUL_OPS
		&& dq_s != fqr_pkg::V_SIMUL_OPS && ce_in |=> mism_r)
		else $error("simultaneous ops mismatch not flagged");
endmodule
`default_nettype wire

//--- rtl/fqr_pkg.sv
package fqr_pkg;
	// flash pin timing, in ns or us as printed
	localparam int CLK_NS = 50;
	localparam int SUPPLY_TO_RESET_RELEASE_TIME_US = 300;
	localparam int RESET_RELEASE_TO_ACCESS_TIME_NS = 50;
	localparam int RESET_RELEASE_TO_WRITE_TIME_NS = 150;
	localparam int RESET_PULSE_TIME_NS = 100;
	localparam int READY_TO_ACCESS_TIME_NS = 0;
	localparam int ABORT_TO_READ_TIME_US = 25;
	localparam int ACCESS_TIME_NS = 70;
	localparam int OE_TIME_NS = 25;
	// cycle counts, least times rounded up; only RH_CYC is held at one or more
	localparam int POWERUP_CYC = (SUPPLY_TO_RESET_RELEASE_TIME_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int RH_CYC_RAW = (RESET_RELEASE_TO_ACCESS_TIME_NS + CLK_NS - 1) / CLK_NS;
	localparam int RH_CYC = RH_CYC_RAW < 1 ? 1 : RH_CYC_RAW;
	localparam int RW_CYC = (RESET_RELEASE_TO_WRITE_TIME_NS + CLK_NS - 1) / CLK_NS;
	localparam int RP_CYC = (RESET_PULSE_TIME_NS + CLK_NS - 1) / CLK_NS;
	localparam int ABORT_CYC = (ABORT_TO_READ_TIME_US * 1000) / CLK_NS;
	localparam int ACC_CYC_RAW = (ACCESS_TIME_NS + CLK_NS - 1) / CLK_NS + 1;
	localparam int ACC_CYC = ACC_CYC_RAW;
	// query table word offsets and expected contents
	localparam logic [7:0] Q_SIMUL_OPS = 8'h4A;
	localparam logic [7:0] Q_BURST = 8'h4B;
	localparam logic [7:0] Q_PAGE = 8'h4C;
	localparam logic [7:0] Q_ACCEL_MIN = 8'h4D;
	localparam logic [7:0] Q_ACCEL_MAX = 8'h4E;
	localparam logic [7:0] Q_WP_PLACE = 8'h4F;
	localparam logic [7:0] Q_PGM_SUSP = 8'h50;
	localparam logic [15:0] V_SIMUL_OPS = 16'h0000;
	localparam logic [15:0] V_BURST = 16'h0000;
	localparam logic [15:0] V_PAGE = 16'h0003;
	localparam logic [15:0] V_ACCEL_MIN = 16'h0085;
	localparam logic [15:0] V_ACCEL_MAX = 16'h0095;
	localparam logic [15:0] V_WP_LOW = 16'h0004;
	localparam logic [15:0] V_WP_HIGH = 16'h0005;
	localparam logic [15:0] V_PGM_SUSP = 16'h0001;
	// controller registers, byte addresses
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_CMD = 8'h04;
	localparam logic [7:0] A_STATUS = 8'h08;
	localparam logic [7:0] A_RDATA = 8'h0C;
	localparam logic [7:0] A_CAPS = 8'h10;
	localparam int CTRL_RST_BIT = 0;
	localparam int CMD_WRITE_BIT = 31;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [5:0] {
		FQR_POWERUP = 6'h01,
		FQR_RESET = 6'h02,
		FQR_IDLE = 6'h04,
		FQR_READ = 6'h08,
		FQR_WRITE = 6'h10,
		FQR_DONE = 6'h20
	} fqr_state_t;
endpackage

//--- rtl/fqr_sync.sv
`timescale 1ns/1ns
`default_nettype none
module fqr_sync #(
	parameter int W = 1
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic ce_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s1_nxt;
	logic [W-1:0] s2_nxt;
	always_comb begin
		s1_nxt = ce_in ? d_in : s1_r;
		s2_nxt = ce_in ? s1_r : s2_r;
	end
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			s1_r <= '1;
			s2_r <= '1;
		end else begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
		end
	end
	assign q_out = s2_r;
endmodule
`default_nettype wire

//--- rtl/fqr_axil.sv
`timescale 1ns/1ns
`default_nettype none
// axi4-lite slave front end: one write and one read at a time
module fqr_axil (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic ce_in,
	input wire logic [7:0] awaddr_in,
	input wire logic awvalid_in,
	output logic awready_out,
	input wire logic [31:0] wdata_in,
	input wire logic [3:0] wstrb_in,
	input wire logic wvalid_in,
	output logic wready_out,
	output logic [1:0] bresp_out,
	output logic bvalid_out,
	input wire logic bready_in,
	input wire logic [7:0] araddr_in,
	input wire logic arvalid_in,
	output logic arready_out,
	output logic [31:0] rdata_out,
	output logic [1:0] rresp_out,
	output logic rvalid_out,
	input wire logic rready_in,
	output logic wr_out,
	output logic [7:0] wr_addr_out,
	output logic [31:0] wr_data_out,
	input wire logic wr_err_in,
	output logic [7:0] rd_addr_out,
	input wire logic [31:0] rd_data_in,
	input wire logic rd_err_in
);
	logic aw_r, w_r, b_r, r_r;
	logic aw_nxt, w_nxt, b_nxt, r_nxt;
	logic [7:0] awa_r, awa_nxt;
	logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt;
	logic [1:0] br_r, br_nxt, rr_r, rr_nxt;
	logic fire;
	always_comb begin
		aw_nxt = aw_r;
		w_nxt = w_r;
		awa_nxt = awa_r;
		wd_nxt = wd_r;
		b_nxt = b_r;
		br_nxt = br_r;
		r_nxt = r_r;
		rr_nxt = rr_r;
		rd_nxt = rd_r;
		fire = 1'b0;
		if (awvalid_in && !aw_r && !b_r) begin
			aw_nxt = 1'b1;
			awa_nxt = awaddr_in;
		end
		if (wvalid_in && !w_r && !b_r) begin
			w_nxt = 1'b1;
			// partial strobes keep only their lanes; the other lanes are written as zero
			wd_nxt = wdata_in & {{8{wstrb_in[3]}}, {8{wstrb_in[2]}}, {8{wstrb_in[1]}}, {8{wstrb_in[0]}}};
		end
		if (aw_r && w_r && !b_r) begin
			fire = 1'b1;
			aw_nxt = 1'b0;
			w_nxt = 1'b0;
			b_nxt = 1'b1;
			br_nxt = wr_err_in ? fqr_pkg::RESP_SLVERR : fqr_pkg::RESP_OKAY;
		end
		if (b_r && bready_in)
			b_nxt = 1'b0;
		if (arvalid_in && !r_r) begin
			r_nxt = 1'b1;
			rd_nxt = rd_data_in;
			rr_nxt = rd_err_in ? fqr_pkg::RESP_SLVERR : fqr_pkg::RESP_OKAY;
		end else if (r_r && rready_in) begin
			r_nxt = 1'b0;
		end
	end
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			aw_r <= 1'b0;
			w_r <= 1'b0;
			b_r <= 1'b0;
			r_r <= 1'b0;
			awa_r <= 8'h00;
			wd_r <= 32'h0000_0000;
			rd_r <= 32'h0000_0000;
			br_r <= 2'h0;
			rr_r <= 2'h0;
		end else if (ce_in) begin
			aw_r <= aw_nxt;
			w_r <= w_nxt;
			b_r <= b_nxt;
			r_r <= r_nxt;
			awa_r <= awa_nxt;
			wd_r <= wd_nxt;
			rd_r <= rd_nxt;
			br_r <= br_nxt;
			rr_r <= rr_nxt;
		end
	end
	assign awready_out = awvalid_in && !aw_r && !b_r && ce_in;
	assign wready_out = wvalid_in && !w_r && !b_r && ce_in;
	assign arready_out = arvalid_in && !r_r && ce_in;
	assign bvalid_out = b_r;
	assign bresp_out = br_r;
	assign rvalid_out = r_r;
	assign rresp_out = rr_r;
	assign rdata_out = rd_r;
	assign wr_out = fire && ce_in;
	assign wr_addr_out = awa_r;
	assign wr_data_out = wd_r;
	assign rd_addr_out = araddr_in;
endmodule
`default_nettype wire

//--- sim/fqr_flash_model.sv
`timescale 1ns/1ns
`default_nettype none
module fqr_flash_model #(
	parameter int PWR_CYC = 20,
	parameter int BUSY_CYC = 200,
	parameter int ABORT_DLY = 3,
	parameter logic [15:0] WP_PLACE = 16'h0004
) (
	input wire logic clk_in,
	input wire logic [7:0] addr_in,
	input wire logic ce_n_in,
	input wire logic oe_n_in,
	input wire logic we_n_in,
	input wire logic rst_n_in,
	input wire logic bad_in,
	output logic [15:0] dq_out,
	output logic ready_busy_n_out,
	output logic [7:0] viol_out
);
	int low_c = 0;
	int high_c = 0;
	int busy_c = 0;
	int acc_c = 0;
	logic first_r = 1'b1;
	logic locked_r = 1'b0;
	logic we_q = 1'b1;
	logic [15:0] last_r = 16'h0000;
	initial viol_out = 8'h00;
	function automatic logic [15:0] query(input logic [7:0] a);
		case (a)
			8'h4A: return 16'h0000;
			8'h4B: return 16'h0000;
			8'h4C: return 16'h0003;
			8'h4D: return 16'h0085;
			8'h4E: return 16'h0095;
			8'h4F: return WP_PLACE;
			8'h50: return 16'h0001;
			default: return {8'h00, a} ^ 16'h5A5A;
		endcase
	endfunction
	// released bus flips every cycle so a stale word never looks valid
	always_comb begin
		if (rst_n_in && !ce_n_in && !oe_n_in && !locked_r && busy_c == 0 && acc_c >= 2) begin
			// bad_in spoils one entry so the host's mismatch flag gets exercised
			dq_out = query(addr_in) ^ {15'h0000, bad_in && addr_in == 8'h4A};
		end else begin
			dq_out = ~last_r;
		end
	end
	assign ready_busy_n_out = (busy_c == 0);
	always @(posedge clk_in) begin
		last_r <= dq_out;
		we_q <= we_n_in;
		acc_c <= (!ce_n_in && !oe_n_in) ? acc_c + 1 : 0;
		// unknown before the host's first reset counts as held low
		if (rst_n_in !== 1'b1) begin
			low_c <= low_c + 1;
			high_c <= 0;
			if (busy_c > ABORT_DLY) busy_c <= ABORT_DLY;
			else if (busy_c > 0) busy_c <= busy_c - 1;
		end else begin
			if (high_c == 0) begin
				locked_r <= low_c < (first_r ? PWR_CYC : 2);
				first_r <= 1'b0;
			end
			low_c <= 0;
			if (high_c < 1000) high_c <= high_c + 1;
			if (high_c < 1 && (!ce_n_in || !oe_n_in)) viol_out <= viol_out + 8'h01;
			if (high_c < 3 && !we_n_in) viol_out <= viol_out + 8'h01;
			if (!we_q && we_n_in && !ce_n_in && !locked_r) busy_c <= BUSY_CYC;
			else if (busy_c > 0) busy_c <= busy_c - 1;
		end
	end
endmodule
`default_nettype wire

//--- sim/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
	$display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb_top;
	typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} fqr_exp_t;
	logic clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic bad = 1'b0;
	wire logic awready, wready, bvalid, arready, rvalid, dq_oe, ce_n, oe_n, we_n, frst_n, rb_n;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [7:0] faddr, viol;
	wire logic [15:0] host_dq, mdl_dq, dq;
	logic [31:0] seed = 32'h0001_7D13;
	logic [15:0] qv [7] = '{16'h0000, 16'h0000, 16'h0003, 16'h0085, 16'h0095, 16'h0004, 16'h0001};
	fqr_exp_t expq[$];
	fqr_exp_t e;
	int n_fail = 0;
	int checks = 0;
	always #25 clk_in = ~clk_in;
	assign dq = dq_oe ? host_dq : mdl_dq;
	fqr_host #(.POWERUP_CYCLES(20), .ABORT_CYCLES(10)) uut (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(1'b1),
		.s_awaddr_in(awaddr), .s_awvalid_in(awvalid), .s_awready_out(awready), .s_wdata_in(wdata),
		.s_wstrb_in(4'hF), .s_wvalid_in(wvalid), .s_wready_out(wready), .s_bresp_out(bresp),
		.s_bvalid_out(bvalid), .s_bready_in(bready), .s_araddr_in(araddr), .s_arvalid_in(arvalid),
		.s_arready_out(arready), .s_rdata_out(rdata), .s_rresp_out(rresp), .s_rvalid_out(rvalid),
		.s_rready_in(rready), .fl_addr_out(faddr), .fl_dq_in(dq), .fl_dq_out(host_dq), .fl_dq_oe_out(dq_oe),
		.fl_ce_n_out(ce_n), .fl_oe_n_out(oe_n), .fl_we_n_out(we_n), .fl_rst_n_out(frst_n),
		.ready_busy_n_in(rb_n));
	fqr_flash_model mdl (.clk_in(clk_in), .addr_in(faddr), .ce_n_in(ce_n), .oe_n_in(oe_n), .we_n_in(we_n),
		.rst_n_in(frst_n), .bad_in(bad), .dq_out(mdl_dq), .ready_busy_n_out(rb_n), .viol_out(viol));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic report_and_stop();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic hang();
		n_fail++;
		$display("wrong value handshake expected done seen timeout");
		report_and_stop();
	endtask
	// results are compared in order of completion, one transfer at a time
	always @(posedge clk_in) begin
		if ((bvalid && bready) || (rvalid && rready)) begin
			if (expq.size() == 0) begin
				n_fail++;
				$display("wrong value queue expected 1 seen 0");
			end else begin
				e = expq.pop_front();
				`CHK("data", e.d & e.m, (bvalid ? 32'h0 : rdata) & e.m)
				`CHK("resp", e.r, bvalid ? bresp : rresp)
			end
		end
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		bit ta = 0;
		bit tw = 0;
		bit gb = 0;
		int n;
		expq.push_back('{32'h0, 32'h0, r});
		@(posedge clk_in);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(negedge clk_in);
			gb = bvalid;
			if (awvalid && awready) ta = 1;
			if (wvalid && wready) tw = 1;
			@(posedge clk_in);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (gb) break;
		end
		bready <= 1'b0;
		if (n == 200) hang();
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input logic [1:0] r,
		output logic [31:0] q);
		bit ta = 0;
		bit gr = 0;
		int n;
		expq.push_back('{d, m, r});
		@(posedge clk_in);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(negedge clk_in);
			gr = rvalid;
			q = rdata;
			if (arvalid && arready) ta = 1;
			@(posedge clk_in);
			if (ta) arvalid <= 1'b0;
			if (gr) break;
		end
		rready <= 1'b0;
		if (n == 200) hang();
	endtask
	task automatic wait_idle();
		logic [31:0] q;
		int n;
		for (n = 0; n < 100; n++) begin
			rd(8'h08, 32'h0, 32'h0, 2'h0, q);
			if (q[4] === 1'b0) break;
		end
		if (n == 100) hang();
	endtask
	task automatic query_rd(input int idx);
		logic [31:0] q;
		wr(8'h04, {8'h00, 8'h4A + idx[7:0], 16'h0000}, 2'h0);
		wait_idle();
		rd(8'h0C, {16'h0, qv[idx]}, 32'h0000_FFFF, 2'h0, q);
	endtask
	initial begin
		int i;
		logic [31:0] q;
		repeat (5) @(posedge clk_in);
		rstn_in <= 1'b1;
		for (i = 0; i < 100 && frst_n !== 1'b1; i++) @(posedge clk_in);
		if (i == 100) hang();
		// release is seen one edge late, so 20 held cycles count as 21
		`CHK("powerup hold", 1'b1, i > 20)
		rd(8'h00, 32'h0, 32'hFFFF_FFFF, 2'h0, q);
		// all entries in order, then a few in random order
		for (i = 0; i < 11; i++) begin
			seed = lfsr(seed);
			query_rd(i < 7 ? i : int'(seed % 7));
		end
		rd(8'h10, 32'h7F, 32'h7F, 2'h0, q);
		rd(8'h08, 32'h0, 32'h40, 2'h0, q);
		seed = lfsr(seed);
		wr(8'h1C, seed, 2'h2);
		rd(8'h1C, 32'h0, 32'hFFFF_FFFF, 2'h2, q);
		// program left running, then aborted by a flash reset
		seed = lfsr(seed);
		wr(8'h04, {8'h80, 8'h20, seed[15:0]}, 2'h0);
		repeat (25) @(posedge clk_in);
		rd(8'h08, 32'h80, 32'hA0, 2'h0, q);
		wr(8'h00, 32'h1, 2'h0);
		repeat (2) @(posedge clk_in);
		wr(8'h00, 32'h0, 2'h0);
		repeat (6) @(posedge clk_in);
		rd(8'h08, 32'h20, 32'h20, 2'h0, q);
		query_rd(2);
		query_rd(6);
		// a wrong entry must clear its capability bit and set the sticky flag
		bad <= 1'b1;
		wr(8'h04, {8'h00, 8'h4A, 16'h0000}, 2'h0);
		wait_idle();
		rd(8'h0C, 32'h0001, 32'h0000_FFFF, 2'h0, q);
		rd(8'h08, 32'h40, 32'h40, 2'h0, q);
		rd(8'h10, 32'h7E, 32'h7F, 2'h0, q);
		`CHK("pin timing", 8'h00, viol)
		report_and_stop();
	end
endmodule
`default_nettype wire
